// File: rtl/mps_alu.sv
`timescale 1ns/100ps
module mps_alu
    import mps_pkg::*;
(
    input  wire logic [3:0] i_op,
    input  wire logic [7:0] i_a,
    input  wire logic [7:0] i_b,
    input  wire logic       i_c,
    output logic      [7:0] o_res,
    output logic      [3:0] o_flags
);
    logic [8:0] sum;
    logic       ac;
    logic [7:0] adj;

    // ****************************************************************
    // Eight-bit datapath
    // ****************************************************************
    always_comb begin
        sum = 9'h000;
        ac  = 1'b0;
        adj = 8'h00;
        unique case (mps_aluop_t'(i_op))
            ALU_ADD:  sum = {1'b0, i_a} + {1'b0, i_b};
            ALU_ADC:  sum = {1'b0, i_a} + {1'b0, i_b} + {8'h00, i_c};
            ALU_SUB:  sum = {1'b0, i_a} + {1'b0, ~i_b} + 9'h001;
            ALU_SBC:  sum = {1'b0, i_a} + {1'b0, ~i_b} + {8'h00, i_c};
            ALU_DAA: begin
                adj[3:0] = (i_a[3:0] > 4'h9) ? 4'h6 : 4'h0;
                adj[7:4] = (i_a[7:4] > 4'h9 || i_c) ? 4'h6 : 4'h0;
                sum = {1'b0, i_a} + {1'b0, adj};
                sum[8] = sum[8] | i_c;
            end
            ALU_AND:  sum = {1'b0, i_a & i_b};
            ALU_OR:   sum = {1'b0, i_a | i_b};
            ALU_XOR:  sum = {1'b0, i_a ^ i_b};
            ALU_CPL:  sum = {1'b0, ~i_a};
            ALU_RR:   sum = {1'b0, i_a[0], i_a[7:1]};
            ALU_RRC:  sum = {i_a[0], i_c, i_a[7:1]};
            ALU_RL:   sum = {1'b0, i_a[6:0], i_a[7]};
            ALU_RLC:  sum = {i_a[7], i_a[6:0], i_c};
            ALU_INC:  sum = {1'b0, i_a} + 9'h001;
            ALU_DEC:  sum = {1'b0, i_a} + 9'h1ff;
            ALU_PASS: sum = {1'b0, i_b};
        endcase
        ac = ((i_a[3:0] + i_b[3:0]) > 5'h0f);
        o_res = sum[7:0];
        o_flags = 4'h0;
        o_flags[ST_C]  = sum[8];
        o_flags[ST_AC] = ac;
        o_flags[ST_Z]  = (sum[7:0] == 8'h00);
        o_flags[ST_OV] = (i_a[7] == i_b[7]) && (sum[7] != i_a[7]);
    end
endmodule : mps_alu

// File: rtl/mps_pkg.sv
package mps_pkg;
    // ****************************************************************
    // Register map (byte offsets, one 32-bit word every four bytes)
    // ****************************************************************
    localparam logic [7:0] REG_CTRL      = 8'h00;
    localparam logic [7:0] REG_PC_LOW    = 8'h04;
    localparam logic [7:0] REG_PC_FULL   = 8'h08;
    localparam logic [7:0] REG_STATUS    = 8'h0c;
    localparam logic [7:0] REG_ALU_OPER  = 8'h10;
    localparam logic [7:0] REG_ALU_RES   = 8'h14;

    // ****************************************************************
    // Control register fields
    // ****************************************************************
    localparam int CTRL_RUN_BIT    = 0;
    localparam int CTRL_IRQ_EN_BIT = 1;
    localparam int CTRL_BANK_LO    = 2;
    localparam int CTRL_BANK_HI    = 3;

    // ****************************************************************
    // Status register fields
    // ****************************************************************
    localparam int ST_C  = 0;
    localparam int ST_AC = 1;
    localparam int ST_Z  = 2;
    localparam int ST_OV = 3;

    localparam int        PHASES      = 4;
    localparam int        PAGE_BITS   = 8;
    localparam logic [7:0] RESET_VEC  = 8'h00;
    localparam logic [15:0] IRQ_VEC   = 16'h0004;

    // ****************************************************************
    // Instruction word layout: [15:12] class, [11:0] operand
    // ****************************************************************
    typedef enum logic [3:0] {
        OP_NOP   = 4'h0,
        OP_ALU   = 4'h1,
        OP_JMP   = 4'h2,
        OP_CALL  = 4'h3,
        OP_RET   = 4'h4,
        OP_RETURN_FROM_INTERRUPT_INSTRUCTION  = 4'h5,
        OP_SZ    = 4'h6,
        OP_SNZ   = 4'h7,
        OP_MOVPL = 4'h8
    } mps_class_t;

    typedef enum logic [3:0] {
        ALU_ADD, ALU_ADC, ALU_SUB, ALU_SBC, ALU_DAA, ALU_AND, ALU_OR,
        ALU_XOR, ALU_CPL, ALU_RR, ALU_RRC, ALU_RL, ALU_RLC, ALU_INC,
        ALU_DEC, ALU_PASS
    } mps_aluop_t;
endpackage : mps_pkg

// File: rtl/mps_sequencer.sv
`timescale 1ns/100ps
// Overview of operation
// - Four phases from clock make one cycle
// - PC advances, fetch starts at phase one
// - Decode and execute in phases two-four
// - Fetch overlaps execute, one per cycle
// - Branches take two instruction cycles
// - Taken skip turns prefetch into dummy
// - Sequential instructions increment PC by one
// - Jumps, calls, interrupt, reset load PC
// - PC width per variant plus bank bits
// - Low byte writable, jump within page
// - Low byte write inserts dummy cycle
// - Stack holds PC only, hidden
// - Call or interrupt pushes PC
// - Return pops and restores PC, unless interrupt taken in same phase four
// - Reset points stack pointer to entry zero
// - Full stack defers interrupt acknowledge
// - Call on full stack overflows anyway
// - Stack depth parameter 8, 12, 16
// - Eight-bit ALU through accumulator
// - Result to destination, status updated
// - Full arithmetic, logic, rotate set
module mps_sequencer
    import mps_pkg::*;
#(
    parameter int PC_W     = 13,
    parameter int BANK_W   = 2,
    parameter int STACK_N  = 16
)(
    input  wire logic                  i_mclk,
    input  wire logic                  i_rst_n,
    input  wire logic                  i_wb_cyc,
    input  wire logic                  i_wb_stb,
    input  wire logic                  i_wb_we,
    input  wire logic [7:0]            i_wb_adr,
    input  wire logic [31:0]           i_wb_dat,
    input  wire logic [3:0]            i_wb_sel,
    output logic      [31:0]           o_wb_dat,
    output logic                       o_wb_ack,
    input  wire logic                  i_irq,
    input  wire logic [15:0]           i_pm_data,
    output logic      [PC_W+BANK_W-1:0] o_pm_addr,
    output logic      [3:0]            o_phase,
    output logic                       o_irq_ack
);
    localparam int SP_W = $clog2(STACK_N);
    localparam int AW   = PC_W + BANK_W;

    typedef enum logic [1:0] {PH_T1, PH_T2, PH_T3, PH_T4} mps_phase_t;

    typedef struct packed {
        mps_phase_t              ph;
        logic [AW-1:0]           pc;
        logic [15:0]             ir;
        logic                    dummy;
        logic                    load;
        logic                    run;
        logic                    irq_en;
        logic                    irq_flag;
        logic [7:0]              acc;
        logic [7:0]              alu_b;
        logic [3:0]              alu_op;
        logic [7:0]              res;
        logic [3:0]              status;
        logic [SP_W-1:0]         sp;
        logic [SP_W:0]           used;
        logic                    ack;
        logic [31:0]             rdat;
        logic                    irq_ack;
    } mps_state_t;

    mps_state_t      st_r;
    mps_state_t      st_nxt;
    logic [AW-1:0]   stack_r [STACK_N];
    logic [1:0]      rst_sync_r;
    logic            rst_n;
    logic [7:0]      alu_res;
    logic [3:0]      alu_flags;
    logic            push;
    logic [SP_W-1:0] push_idx;
    logic [AW-1:0]   push_val;
    logic            stack_full;
    logic            wb_req;
    logic [AW-1:0]   pc_inc;

    // ****************************************************************
    // Reset release
    // ****************************************************************
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rst_sync_r <= 2'b00;
        end else begin
            rst_sync_r <= {rst_sync_r[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_r[1];

    mps_alu u_alu (
        .i_op    (st_r.alu_op),
        .i_a     (st_r.acc),
        .i_b     (st_r.alu_b),
        .i_c     (st_r.status[ST_C]),
        .o_res   (alu_res),
        .o_flags (alu_flags)
    );

    assign stack_full = (st_r.used == (SP_W+1)'(STACK_N));
    assign wb_req     = i_wb_cyc && i_wb_stb && !st_r.ack;
    assign pc_inc     = st_r.pc + AW'(1);

    // ****************************************************************
    // Sequencer
    // ****************************************************************
    always_comb begin
        st_nxt   = st_r;
        push     = 1'b0;
        push_idx = st_r.sp;
        push_val = st_r.pc;
        st_nxt.ack = wb_req;
        st_nxt.irq_ack = 1'b0;
        if (i_irq && st_r.irq_en) begin
            st_nxt.irq_flag = 1'b1;
        end
        if (st_r.run) begin
            st_nxt.ph = (st_r.ph == PH_T4) ? PH_T1 : mps_phase_t'(st_r.ph + 2'd1);
        end
        if (st_r.run) begin
        unique case (st_r.ph)
            PH_T1: begin
                if (st_r.load) begin
                    st_nxt.load = 1'b0;
                end else begin
                    st_nxt.pc = pc_inc;
                end
            end
            PH_T2: begin
                if (!st_r.dummy && st_r.ir[15:12] == OP_ALU) begin
                    st_nxt.alu_op = st_r.ir[11:8];
                    st_nxt.alu_b  = st_r.ir[7:0];
                end
            end
            PH_T3: begin
                if (!st_r.dummy && st_r.ir[15:12] == OP_ALU) begin
                    st_nxt.res = alu_res;
                end
            end
            PH_T4: begin
                st_nxt.ir    = i_pm_data;
                st_nxt.dummy = 1'b0;
                if (st_r.run && !st_r.dummy) begin
                    unique case (st_r.ir[15:12])
                        OP_ALU: begin
                            st_nxt.acc    = st_r.res;
                            st_nxt.status = alu_flags;
                        end
                        OP_JMP: begin
                            st_nxt.pc[PC_W-2:0] = st_r.ir[PC_W-2:0];
                            st_nxt.load  = 1'b1;
                            st_nxt.dummy = 1'b1;
                        end
                        OP_CALL: begin
                            push = 1'b1;
                            st_nxt.pc[PC_W-2:0] = st_r.ir[PC_W-2:0];
                            st_nxt.load  = 1'b1;
                            st_nxt.dummy = 1'b1;
                        end
                        OP_RET, OP_RETURN_FROM_INTERRUPT_INSTRUCTION: begin
                            st_nxt.pc = stack_r[st_r.sp - SP_W'(1)];
                            st_nxt.load = 1'b1;
                            st_nxt.sp = st_r.sp - SP_W'(1);
                            st_nxt.used = (st_r.used == '0) ? st_r.used : st_r.used - 1'b1;
                            st_nxt.dummy = 1'b1;
                            if (st_r.ir[15:12] == OP_RETURN_FROM_INTERRUPT_INSTRUCTION) begin
                                st_nxt.irq_en = 1'b1;
                            end
                        end
                        OP_SZ, OP_SNZ: begin
                            if ((st_r.acc == 8'h00) == (st_r.ir[15:12] == OP_SZ)) begin
                                st_nxt.dummy = 1'b1;
                            end
                        end
                        OP_MOVPL: begin
                            st_nxt.pc[PAGE_BITS-1:0] = st_r.acc;
                            st_nxt.load  = 1'b1;
                            st_nxt.dummy = 1'b1;
                        end
                        default: ;
                    endcase
                end
                if (st_r.irq_flag && st_r.irq_en && !stack_full && !push) begin
                    push = 1'b1;
                    push_val = st_nxt.pc;
                    st_nxt.pc = AW'(IRQ_VEC);
                    st_nxt.load = 1'b1;
                    st_nxt.irq_flag = i_irq && st_r.irq_en;
                    st_nxt.irq_en = 1'b0;
                    st_nxt.irq_ack = 1'b1;
                    st_nxt.dummy = 1'b1;
                end
                if (push) begin
                    st_nxt.sp = st_r.sp + SP_W'(1);
                    if (!stack_full) begin
                        st_nxt.used = st_r.used + 1'b1;
                    end
                end
            end
        endcase
        end
        if (wb_req && i_wb_we && i_wb_sel[0]) begin
            unique case (i_wb_adr)
                REG_CTRL: begin
                    st_nxt.run    = i_wb_dat[CTRL_RUN_BIT];
                    st_nxt.irq_en = i_wb_dat[CTRL_IRQ_EN_BIT];
                    if (BANK_W > 0) begin
                        st_nxt.pc[AW-1:PC_W] = i_wb_dat[CTRL_BANK_LO +: BANK_W];
                    end
                end
                REG_PC_LOW: begin
                    st_nxt.pc[PAGE_BITS-1:0] = i_wb_dat[7:0];
                    st_nxt.load  = 1'b1;
                    st_nxt.dummy = 1'b1;
                end
                REG_ALU_OPER: begin
                    st_nxt.acc = i_wb_dat[7:0];
                end
                default: ;
            endcase
        end
        st_nxt.rdat = 32'h0000_0000;
        if (wb_req && !i_wb_we) begin
            unique case (i_wb_adr)
                REG_CTRL:     st_nxt.rdat = 32'({st_r.irq_en, st_r.run});
                REG_PC_LOW:   st_nxt.rdat = 32'(st_r.pc[PAGE_BITS-1:0]);
                REG_PC_FULL:  st_nxt.rdat = 32'(st_r.pc);
                REG_STATUS:   st_nxt.rdat = 32'({st_r.irq_flag, st_r.status});
                REG_ALU_OPER: st_nxt.rdat = 32'(st_r.acc);
                REG_ALU_RES:  st_nxt.rdat = 32'(st_r.res);
                default:      st_nxt.rdat = 32'h0000_0000;
            endcase
        end
        if (push) begin
            push_idx = st_r.sp;
        end
    end

    always_ff @(posedge i_mclk or negedge rst_n) begin
        if (!rst_n) begin
            st_r     <= '0;
            st_r.pc  <= AW'(RESET_VEC);
            st_r.sp  <= '0;
            st_r.run <= 1'b1;
            st_r.dummy <= 1'b1;
            st_r.load  <= 1'b1;
        end else begin
            st_r <= st_nxt;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (push) begin
            stack_r[push_idx] <= push_val;
        end
    end

    assign o_pm_addr = st_r.pc;
    assign o_wb_ack  = st_r.ack;
    assign o_wb_dat  = st_r.rdat;
    assign o_irq_ack = st_r.irq_ack;
    always_comb begin
        o_phase = 4'h0;
        o_phase[st_r.ph] = st_r.run;
    end

    // ****************************************************************
    // Checks
    // ****************************************************************
    phase_order_a : assert property (@(posedge i_mclk) disable iff (!rst_n)
        st_r.run && st_nxt.run && st_r.ph == PH_T4 |=> st_r.ph == PH_T1)
        else $error("phase did not wrap");
    pc_step_a : assert property (@(posedge i_mclk) disable iff (!rst_n)
        st_r.run && st_r.ph == PH_T1 && !st_r.load && !wb_req
        |=> st_r.pc == $past(st_r.pc) + AW'(1))
        else $error("pc not advanced in phase one");
    pcl_dummy_a : assert property (@(posedge i_mclk) disable iff (!rst_n)
        wb_req && i_wb_we && i_wb_sel[0] && i_wb_adr == REG_PC_LOW |=> st_r.dummy)
        else $error("no dummy after low byte write");
    irq_defer_a : assert property (@(posedge i_mclk) disable iff (!rst_n)
        stack_full |-> !st_nxt.irq_ack)
        else $error("interrupt acknowledged on full stack");
    ack_drop_a : assert property (@(posedge i_mclk) disable iff (!rst_n)
        o_wb_ack |=> !o_wb_ack)
        else $error("ack held two cycles");
    used_cap_a : assert property (@(posedge i_mclk) disable iff (!rst_n)
        st_r.used <= (SP_W+1)'(STACK_N))
        else $error("stack level count past depth");
    ret_pop_a : assert property (@(posedge i_mclk) disable iff (!rst_n)
        st_r.ph == PH_T4 && st_r.run && !st_r.dummy && st_r.ir[15:12] == OP_RET
        |=> st_r.sp == $past(st_r.sp) - SP_W'(1))
        else $error("return did not pop");
    skip_dummy_a : assert property (@(posedge i_mclk) disable iff (!rst_n)
        st_r.ph == PH_T4 && st_r.run && !st_r.dummy && st_r.ir[15:12] == OP_SZ
        && st_r.acc == 8'h00 |=> st_r.dummy)
        else $error("taken skip gave no dummy");
endmodule : mps_sequencer

// File: tb/mps_pm_model.sv
`timescale 1ns/100ps
// ****************************************************************
// Program memory at the fetch port
// ****************************************************************
module mps_pm_model #(
    parameter int AW = 15
)(
    input  wire logic [AW-1:0] i_addr,
    output logic      [15:0]   o_data
);
    logic [15:0] mem [0:511];

    initial begin
        for (int i = 0; i < 512; i++) begin
            mem[i] = 16'h0000;
        end
    end

    task automatic put(input logic [8:0] a, input logic [15:0] d);
        mem[a] = d;
    endtask : put

    // Outside the loaded range the word is scrambled, not held
    always @* begin
        if (i_addr < AW'(512)) begin
            o_data = mem[i_addr[8:0]];
        end else begin
            o_data = ~mem[i_addr[8:0]];
        end
    end
endmodule : mps_pm_model

// File: tb/tb_top.sv
`timescale 1ns/100ps
module tb_top;
    import mps_pkg::*;
    logic        i_mclk = 1'b0;
    logic        i_rst_n = 1'b0;
    logic        cyc = 1'b0;
    logic        stb = 1'b0;
    logic        we = 1'b0;
    logic [7:0]  adr = 8'h00;
    logic [31:0] wdat = 32'h0;
    logic [3:0]  sel = 4'h0;
    logic [31:0] rdat;
    logic        ack;
    logic        irq = 1'b0;
    logic [15:0] pm_data;
    logic [14:0] pm_addr;
    logic [3:0]  phase;
    logic        irq_ack;
    logic [31:0] q;
    int          failures = 0;
    int          n_checks = 0;
    int          n_ack = 0;

    always #25 i_mclk = ~i_mclk;

    mps_sequencer dut (
        .i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_wb_cyc(cyc), .i_wb_stb(stb),
        .i_wb_we(we), .i_wb_adr(adr), .i_wb_dat(wdat), .i_wb_sel(sel),
        .o_wb_dat(rdat), .o_wb_ack(ack), .i_irq(irq), .i_pm_data(pm_data),
        .o_pm_addr(pm_addr), .o_phase(phase), .o_irq_ack(irq_ack)
    );
    mps_pm_model #(.AW(15)) pm (.i_addr(pm_addr), .o_data(pm_data));

    // ****************************************************************
    // Reporting
    // ****************************************************************
    task automatic err(input string m);
        failures++;
        $display("Error at %0t: %s", $time, m);
    endtask : err

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        n_checks++;
        if (got !== exp) begin
            err($sformatf("%s got %h exp %h", m, got, exp));
        end
    endtask : chk

    task automatic end_of_test;
        $display("checks %0d mismatches %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : end_of_test

    // ****************************************************************
    // Bus and wait helpers
    // ****************************************************************
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r);
        int n;
        n = 0;
        @(posedge i_mclk);
        cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d; sel <= 4'hf;
        do begin
            @(posedge i_mclk);
            n++;
        end while (ack !== 1'b1 && n < 50);
        if (ack !== 1'b1) begin
            err("no bus ack");
            end_of_test();
        end
        r = rdat;
        cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
        @(posedge i_mclk);
    endtask : wb

    task automatic wait_pc(input logic [14:0] a);
        int n;
        n = 0;
        do begin
            @(posedge i_mclk);
            n++;
        end while (pm_addr !== a && n < 2000);
        if (pm_addr !== a) begin
            err($sformatf("fetch never reached %h", a));
            end_of_test();
        end
    endtask : wait_pc

    // A taken skip must never let the trap word run
    always @(posedge i_mclk) begin
        if (pm_addr === 15'h00ff) begin
            err("skipped branch was taken");
        end
        if (irq_ack === 1'b1) begin
            n_ack++;
        end
    end

    // ****************************************************************
    // Test sequence
    // ****************************************************************
    initial begin
        @(posedge i_mclk);
        pm.put(9'h000, 16'h2010);
        pm.put(9'h004, 16'h1f77);
        pm.put(9'h005, 16'h5000);
        pm.put(9'h010, 16'h1f80);
        pm.put(9'h011, 16'h1080);
        pm.put(9'h012, 16'h6000);
        pm.put(9'h013, 16'h20ff);
        pm.put(9'h014, 16'h3020);
        pm.put(9'h015, 16'h8000);
        pm.put(9'h020, 16'h1f33);
        pm.put(9'h021, 16'h4000);
        pm.put(9'h033, 16'h2033);
        pm.put(9'h040, 16'h1f5a);
        pm.put(9'h041, 16'h2041);
        pm.put(9'h0ff, 16'h1fee);
        repeat (10) @(posedge i_mclk);
        i_rst_n <= 1'b1;
        repeat (3) @(posedge i_mclk);
        for (int n = 0; n < 20 && phase !== 4'h1; n++) begin
            @(posedge i_mclk);
        end
        if (phase !== 4'h1) begin
            err("phase one never seen");
            end_of_test();
        end
        for (int k = 1; k < 9; k++) begin
            @(posedge i_mclk);
            chk(32'(phase), 32'(4'h1 << (k % 4)), "phase");
        end
        $display("test phases done");
        wb(1'b0, 8'h3c, 32'h0, q);
        chk(q, 32'h0, "unmapped read");
        wait_pc(15'h0033);
        repeat (8) @(posedge i_mclk);
        wb(1'b0, REG_ALU_OPER, 32'h0, q);
        chk(q, 32'h33, "acc after call and return");
        wb(1'b0, REG_ALU_RES, 32'h0, q);
        chk(q, 32'h33, "alu result");
        wb(1'b0, REG_STATUS, 32'h0, q);
        chk(q, 32'h0, "status after pass op");
        $display("test program flow done");
        wb(1'b1, REG_PC_LOW, 32'h40, q);
        wait_pc(15'h0041);
        repeat (8) @(posedge i_mclk);
        wb(1'b0, REG_ALU_OPER, 32'h0, q);
        chk(q, 32'h5a, "acc after page jump");
        $display("test low byte write done");
        wb(1'b1, REG_CTRL, 32'h3, q);
        irq <= 1'b1;
        @(posedge i_mclk);
        irq <= 1'b0;
        for (int n = 0; n < 200 && irq_ack !== 1'b1; n++) begin
            @(posedge i_mclk);
        end
        if (irq_ack !== 1'b1) begin
            err("no interrupt acknowledge");
            end_of_test();
        end
        wait_pc(IRQ_VEC[14:0] + 15'h1);
        wait_pc(15'h0041);
        repeat (8) @(posedge i_mclk);
        chk(32'(n_ack), 32'd1, "interrupt ack count");
        wb(1'b0, REG_ALU_OPER, 32'h0, q);
        chk(q, 32'h77, "acc after interrupt");
        $display("test interrupt done");
        end_of_test();
    end
endmodule : tb_top
